// ---- hdl/cal_pkg.sv ----
// shared types and constants of the meter calibration control
// assumes a 200 MHz clock; keys and flow pulses arrive from pins
package cal_pkg;
   localparam int CLK_MHZ = 200;
   localparam int DEBOUNCE_MS = 20;
   localparam int LONG_PRESS_MS = 1000;
   localparam int STANDBY_MS = 3000;
   localparam int RESTART_MS = 10;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_MHZ * 1000;
   localparam int LONG_CYC = LONG_PRESS_MS * CLK_MHZ * 1000;
   localparam int STANDBY_CYC = STANDBY_MS * CLK_MHZ * 1000;
   localparam int RESTART_CYC = RESTART_MS * CLK_MHZ * 1000;
   localparam logic [15:0] FACTORY_FACTOR = 16'h03E8; // 1.000 in thousandths
   localparam logic [31:0] ZERO_QTY = 32'h00000000;

   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_STANDBY = 3'h1,
      ST_VIEW = 3'h3,
      ST_FIELD = 3'h2,
      ST_FROZEN = 3'h6,
      ST_SAVE = 3'h7,
      ST_RESTART = 3'h5
   } mode_t;

   typedef struct packed {
      logic short_p;
      logic long_p;
   } press_t;

   typedef struct packed {
      logic wr;
      logic erase_user;
      logic use_user;
      logic [15:0] factor;
   } nvm_req_t;
endpackage

// ---- hdl/key_classify.sv ----
// one key: pin synchroniser, debounce and short/long classification
// assumes an active-high key level from a pin
`timescale 1ns/1ps
module key_classify #(
   parameter int DEB_CYC = cal_pkg::DEBOUNCE_CYC,
   parameter int LONG_CYC = cal_pkg::LONG_CYC
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic key_i,
   output cal_pkg::press_t press_o
);
   typedef struct packed {
      logic [2:0] sync;
      logic level;
      logic [31:0] cnt;
      logic long_done;
      cal_pkg::press_t press;
   } key_state_t;

   key_state_t st_r;
   key_state_t st_nxt;

   // debounce, then time the held level
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync = {st_r.sync[1:0], key_i};
      st_nxt.press = '0;
      if (st_r.sync[2] == st_r.sync[1] && st_r.sync[2] != st_r.level) begin
         st_nxt.level = st_r.sync[2];
         // short release: only when debounce interval passed
         if (!st_r.sync[2] && !st_r.long_done && st_r.cnt >= 32'(DEB_CYC))
            st_nxt.press.short_p = 1'b1;
         st_nxt.cnt = '0;
         st_nxt.long_done = 1'b0;
      end else if (st_r.level) begin
         if (st_r.cnt != 32'hFFFFFFFF)
            st_nxt.cnt = st_r.cnt + 32'h1;
         // long press fires once at the threshold
         if (!st_r.long_done && st_r.cnt >= 32'(LONG_CYC)) begin
            st_nxt.press.long_p = 1'b1;
            st_nxt.long_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign press_o = st_r.press;

   chk_short_long_excl: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !(press_o.short_p && press_o.long_p)) else $error("short and long together");
   chk_long_once: assert property (@(posedge clk_i) disable iff (!rstn_i)
      press_o.long_p |=> !press_o.long_p) else $error("long press repeated");
endmodule

// ---- hdl/meter_cal_ctrl.sv ----
// calibration control of a pulse-counting fuel meter
// assumes keys and flow pulse from pins; storage port accepts a write per cycle
`timescale 1ns/1ps
module meter_cal_ctrl #(
   parameter int STANDBY_CYC = cal_pkg::STANDBY_CYC,
   parameter int RESTART_CYC = cal_pkg::RESTART_CYC,
   parameter int DEB_CYC = cal_pkg::DEBOUNCE_CYC,
   parameter int LONG_CYC = cal_pkg::LONG_CYC
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic flow_pulse_i,
   input wire logic key_cal_i,
   input wire logic key_reset_i,
   input wire logic [15:0] nv_user_factor_i,
   input wire logic nv_use_user_i,
   input wire logic [31:0] nv_partial_i,
   input wire logic [31:0] nv_rtotal_i,
   input wire logic [31:0] nv_gtotal_i,
   input wire logic nv_valid_i,
   output logic [31:0] partial_o,
   output logic [31:0] rtotal_o,
   output logic [31:0] gtotal_o,
   output logic [15:0] factor_o,
   output logic factor_user_o,
   output logic cal_ind_o,
   output logic field_ind_o,
   output logic standby_o,
   output logic frozen_o,
   output cal_pkg::nvm_req_t nv_req_o,
   output logic [31:0] nv_partial_o,
   output logic [31:0] nv_rtotal_o,
   output logic [31:0] nv_gtotal_o
);
   typedef struct packed {
      cal_pkg::mode_t mode;
      logic [2:0] psync;
      logic plevel;
      logic loaded;
      logic [15:0] user_factor;
      logic use_user;
      logic sel_user;
      logic [31:0] partial;
      logic [31:0] rtotal;
      logic [31:0] gtotal;
      logic [31:0] timer;
      cal_pkg::nvm_req_t nv;
      logic [15:0] show_factor;
      logic show_user;
      logic cal_ind;
      logic field_ind;
      logic standby;
      logic frozen;
   } ctl_state_t;

   ctl_state_t s_r;
   ctl_state_t s_nxt;
   cal_pkg::press_t cal_p;
   cal_pkg::press_t rst_p;
   logic pulse;
   logic [15:0] active_factor;

   // both keys debounced and classified first
   key_classify #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_cal_key (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .key_i(key_cal_i),
      .press_o(cal_p)
   );
   key_classify #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_rst_key (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .key_i(key_reset_i),
      .press_o(rst_p)
   );

   // pulse edge once the 2nd and 3rd sync stages agree on a new high level
   assign pulse = s_r.psync[2] && s_r.psync[1] && !s_r.plevel;
   // factory constant is used whenever user factor is not selected
   assign active_factor = s_r.use_user ? s_r.user_factor : cal_pkg::FACTORY_FACTOR;

   // main sequencing
   always_comb begin
      s_nxt = s_r;
      s_nxt.psync = {s_r.psync[1:0], flow_pulse_i};
      if (s_r.psync[2] == s_r.psync[1])
         s_nxt.plevel = s_r.psync[2]; // settled pin level
      s_nxt.nv = '0;
      if (!s_r.loaded) begin
         // restore stored selection and registers at start
         if (nv_valid_i) begin
            s_nxt.loaded = 1'b1;
            s_nxt.user_factor = nv_user_factor_i;
            s_nxt.use_user = nv_use_user_i;
            s_nxt.partial = nv_partial_i;
            s_nxt.rtotal = nv_rtotal_i;
            s_nxt.gtotal = nv_gtotal_i;
            s_nxt.mode = cal_pkg::ST_STANDBY;
         end
      end else begin
         unique case (s_r.mode)
            cal_pkg::ST_RUN: begin
               if (pulse) begin
                  // quantity by active factor per pulse
                  s_nxt.partial = s_r.partial + 32'(active_factor);
                  s_nxt.rtotal = s_r.rtotal + 32'(active_factor);
                  s_nxt.gtotal = s_r.gtotal + 32'(active_factor);
                  s_nxt.timer = '0;
               end else if (s_r.timer >= 32'(STANDBY_CYC)) begin
                  s_nxt.mode = cal_pkg::ST_STANDBY;
               end else begin
                  s_nxt.timer = s_r.timer + 32'h1;
               end
            end
            cal_pkg::ST_STANDBY: begin
               if (pulse) begin
                  s_nxt.mode = cal_pkg::ST_RUN;
                  s_nxt.partial = s_r.partial + 32'(active_factor);
                  s_nxt.rtotal = s_r.rtotal + 32'(active_factor);
                  s_nxt.gtotal = s_r.gtotal + 32'(active_factor);
                  s_nxt.timer = '0;
               end else if (cal_p.long_p) begin
                  // only long cal in standby opens calibration
                  s_nxt.mode = cal_pkg::ST_VIEW;
                  s_nxt.sel_user = s_r.use_user;
               end else if (rst_p.short_p) begin
                  s_nxt.partial = cal_pkg::ZERO_QTY;
                  s_nxt.nv.wr = 1'b1;
               end
            end
            cal_pkg::ST_VIEW: begin
               // totals untouched, pulses ignored here
               if (rst_p.short_p) begin
                  s_nxt.sel_user = !s_r.sel_user;
               end else if (rst_p.long_p) begin
                  s_nxt.mode = cal_pkg::ST_FIELD;
                  s_nxt.partial = cal_pkg::ZERO_QTY;
               end else if (cal_p.short_p) begin
                  // confirm choice; factory choice erases user factor
                  s_nxt.use_user = s_r.sel_user;
                  if (!s_r.sel_user)
                     s_nxt.user_factor = cal_pkg::FACTORY_FACTOR;
                  s_nxt.mode = cal_pkg::ST_SAVE;
               end
            end
            cal_pkg::ST_FIELD: begin
               // partial counts raw factory units across stops
               if (rst_p.short_p)
                  s_nxt.mode = cal_pkg::ST_FROZEN;
               else if (pulse)
                  s_nxt.partial = s_r.partial + 32'(cal_pkg::FACTORY_FACTOR);
            end
            cal_pkg::ST_FROZEN: begin
               // partial held until a short cal press moves to the save step
               if (cal_p.short_p)
                  s_nxt.mode = cal_pkg::ST_SAVE;
            end
            cal_pkg::ST_SAVE: begin
               // store factor before restart begins
               s_nxt.nv.wr = 1'b1;
               s_nxt.nv.erase_user = !s_r.use_user;
               s_nxt.nv.use_user = s_r.use_user;
               s_nxt.nv.factor = s_r.user_factor;
               s_nxt.timer = '0;
               s_nxt.mode = cal_pkg::ST_RESTART;
            end
            cal_pkg::ST_RESTART: begin
               if (s_r.timer >= 32'(RESTART_CYC)) begin
                  s_nxt.mode = cal_pkg::ST_STANDBY;
                  s_nxt.partial = cal_pkg::ZERO_QTY;
               end else begin
                  s_nxt.timer = s_r.timer + 32'h1;
               end
            end
            default: begin
               s_nxt.mode = cal_pkg::ST_STANDBY; // illegal code recovery
            end
         endcase
      end
      // display outputs decoded from the next state, so they leave flops
      s_nxt.show_user = s_nxt.mode == cal_pkg::ST_VIEW ? s_nxt.sel_user : s_nxt.use_user;
      s_nxt.show_factor = s_nxt.show_user ? s_nxt.user_factor : cal_pkg::FACTORY_FACTOR;
      s_nxt.cal_ind = s_nxt.mode inside {cal_pkg::ST_VIEW, cal_pkg::ST_FIELD,
         cal_pkg::ST_FROZEN};
      s_nxt.field_ind = s_nxt.mode inside {cal_pkg::ST_FIELD, cal_pkg::ST_FROZEN};
      s_nxt.standby = s_nxt.mode == cal_pkg::ST_STANDBY;
      s_nxt.frozen = s_nxt.mode == cal_pkg::ST_FROZEN;
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from state flops
   assign partial_o = s_r.partial;
   assign rtotal_o = s_r.rtotal;
   assign gtotal_o = s_r.gtotal;
   assign factor_o = s_r.show_factor;
   assign factor_user_o = s_r.show_user;
   assign cal_ind_o = s_r.cal_ind;
   assign field_ind_o = s_r.field_ind;
   assign standby_o = s_r.standby;
   assign frozen_o = s_r.frozen;
   assign nv_req_o = s_r.nv;
   assign nv_partial_o = s_r.partial;
   assign nv_rtotal_o = s_r.rtotal;
   assign nv_gtotal_o = s_r.gtotal;

   // checks
   chk_totals_frozen_cal: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cal_ind_o |=> $stable(gtotal_o) && $stable(rtotal_o)) else $error("total moved");
   chk_entry_standby: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!cal_ind_o ##1 cal_ind_o) |-> $past(standby_o, 1) && $past(cal_p.long_p, 1))
      else $error("bad entry");
   chk_field_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (s_r.mode == cal_pkg::ST_VIEW && rst_p.long_p) |=> field_ind_o && partial_o == 0)
      else $error("field not cleared");
   chk_toggle_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (s_r.mode == cal_pkg::ST_VIEW && rst_p.short_p) |=> factor_user_o != $past(factor_user_o))
      else $error("no toggle");
   chk_freeze_part: assert property (@(posedge clk_i) disable iff (!rstn_i)
      frozen_o ##1 frozen_o |-> $stable(partial_o)) else $error("frozen moved");
   chk_save_first: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_r.mode == cal_pkg::ST_SAVE |=> nv_req_o.wr ##0 s_r.mode == cal_pkg::ST_RESTART)
      else $error("no store");
   chk_erase_fact: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (nv_req_o.wr && s_r.mode == cal_pkg::ST_RESTART && !factor_user_o) |-> nv_req_o.erase_user)
      else $error("no erase");
   chk_count_factor: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (s_r.mode == cal_pkg::ST_RUN && pulse) |=>
      gtotal_o == $past(gtotal_o) + 32'($past(active_factor))) else $error("bad count");
   cov_enter_cal: cover property (@(posedge clk_i) standby_o ##1 cal_ind_o);
   cov_field_freeze: cover property (@(posedge clk_i) field_ind_o && !frozen_o ##1 frozen_o);
   cov_restart: cover property (@(posedge clk_i) nv_req_o.wr && nv_req_o.use_user);
endmodule

// ---- verification/meter_cal_ctrl_tb.sv ----
// self-checking bench of the meter calibration control: run, view, toggle, confirm, field
// assumes shortened timing parameters and a storage image that is valid from time zero
`timescale 1ns/1ps
module meter_calibration_control_tb;
   localparam int DEB = 4;
   localparam int LONG = 40;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic flow_pulse_i = 1'b0;
   logic key_cal_i = 1'b0;
   logic key_reset_i = 1'b0;
   logic [15:0] nv_user_factor_i = 16'h03E6;
   logic nv_use_user_i = 1'b1;
   logic [31:0] nv_partial_i;
   logic [31:0] nv_rtotal_i;
   logic [31:0] nv_gtotal_i;
   logic nv_valid_i = 1'b1;
   logic [31:0] partial_o;
   logic [31:0] rtotal_o;
   logic [31:0] gtotal_o;
   logic [15:0] factor_o;
   logic factor_user_o;
   logic cal_ind_o;
   logic field_ind_o;
   logic standby_o;
   logic frozen_o;
   cal_pkg::nvm_req_t nv_req_o;
   cal_pkg::nvm_req_t exp_q[$];
   integer seed = 32'h9B63F8B6;
   int failures = 0;
   int checks_done = 0;
   logic [31:0] p_exp;
   logic [31:0] r_exp;
   logic [31:0] g_exp;
   int n;

   meter_cal_ctrl #(.STANDBY_CYC(200), .RESTART_CYC(20), .DEB_CYC(DEB), .LONG_CYC(LONG))
   meter_cal_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i), .flow_pulse_i(flow_pulse_i),
      .key_cal_i(key_cal_i), .key_reset_i(key_reset_i), .nv_user_factor_i(nv_user_factor_i),
      .nv_use_user_i(nv_use_user_i), .nv_partial_i(nv_partial_i), .nv_rtotal_i(nv_rtotal_i),
      .nv_gtotal_i(nv_gtotal_i), .nv_valid_i(nv_valid_i), .partial_o(partial_o),
      .rtotal_o(rtotal_o), .gtotal_o(gtotal_o), .factor_o(factor_o),
      .factor_user_o(factor_user_o), .cal_ind_o(cal_ind_o), .field_ind_o(field_ind_o),
      .standby_o(standby_o), .frozen_o(frozen_o), .nv_req_o(nv_req_o), .nv_partial_o(),
      .nv_rtotal_o(), .nv_gtotal_o());

   // 200 MHz clock
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic tick(input int cyc);
      repeat (cyc) @(posedge clk_i);
      #1;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic sig(input int sel);
      case (sel)
         0: return standby_o;
         1: return cal_ind_o;
         2: return field_ind_o;
         default: return frozen_o;
      endcase
   endfunction

   // bounded wait for a state indication
   task automatic wait_hi(input int sel);
      for (int i = 0; i < 600 && sig(sel) !== 1'b1; i++) tick(1);
      check($sformatf("state_%0d", sel), 32'(sig(sel)), 32'h1);
   endtask

   // hold one key for a number of cycles, then let the press settle
   task automatic key(input bit cal, input int cyc);
      if (cal) key_cal_i = 1'b1;
      else key_reset_i = 1'b1;
      tick(cyc);
      key_cal_i = 1'b0;
      key_reset_i = 1'b0;
      tick(30);
   endtask

   // flow pulses, two cycles high and two low, plus sync latency
   task automatic flow(input int cnt);
      repeat (cnt) begin
         flow_pulse_i = 1'b1;
         tick(2);
         flow_pulse_i = 1'b0;
         tick(2);
      end
      tick(8);
   endtask

   task automatic finish_test;
      if (failures == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // storage write watcher: oldest note against each write pulse
   always @(posedge clk_i) begin
      if (rstn_i === 1'b1 && nv_req_o.wr === 1'b1) begin
         if (exp_q.size() == 0) check("nv_req_extra", 32'(nv_req_o), 32'h0);
         else check("nv_req", 32'(nv_req_o), 32'(exp_q.pop_front()));
      end
   end

   // watchdog well beyond the expected run length
   initial begin
      #100000;
      failures++;
      finish_test;
   end

   initial begin
      nv_partial_i = $random(seed) & 32'h000FFFFF;
      nv_rtotal_i = $random(seed) & 32'h00FFFFFF;
      nv_gtotal_i = $random(seed) & 32'h0FFFFFFF;
      tick(2);
      rstn_i = 1'b1;
      // image load and standby entry
      wait_hi(0);
      check("factor", 32'(factor_o), 32'h03E6);
      check("factor_user", 32'(factor_user_o), 32'h1);
      check("gtotal", gtotal_o, nv_gtotal_i);
      // ordinary dispense with user factor; long cal while running is ignored
      n = 1 + ($unsigned($random(seed)) % 8);
      p_exp = nv_partial_i + 32'(n) * 32'h03E6;
      r_exp = nv_rtotal_i + 32'(n) * 32'h03E6;
      g_exp = nv_gtotal_i + 32'(n) * 32'h03E6;
      flow(n);
      check("partial", partial_o, p_exp);
      check("rtotal", rtotal_o, r_exp);
      check("gtotal", gtotal_o, g_exp);
      key(1'b1, LONG + 20);
      check("cal_ind_run", 32'(cal_ind_o), 32'h0);
      wait_hi(0);
      // entry to the factor view from standby
      key(1'b1, LONG + 20);
      wait_hi(1);
      check("view_factor", 32'(factor_o), 32'h03E6);
      check("view_user", 32'(factor_user_o), 32'h1);
      flow(3);
      check("rtotal_cal", rtotal_o, r_exp);
      check("gtotal_cal", gtotal_o, g_exp);
      // reset presses toggle the proposed factor
      for (int i = 0; i < 3; i++) begin
         key(1'b0, DEB + 8);
         check("toggle_user", 32'(factor_user_o), 32'(i[0]));
         check("toggle_factor", 32'(factor_o), i[0] ? 32'h03E6 : 32'(cal_pkg::FACTORY_FACTOR));
      end
      // confirm factory factor: erase user factor, restart
      exp_q.push_back('{wr: 1'b1, erase_user: 1'b1, use_user: 1'b0,
         factor: cal_pkg::FACTORY_FACTOR});
      key(1'b1, DEB + 8);
      wait_hi(0);
      check("factor_after", 32'(factor_o), 32'(cal_pkg::FACTORY_FACTOR));
      check("user_after", 32'(factor_user_o), 32'h0);
      check("cal_ind_after", 32'(cal_ind_o), 32'h0);
      // field calibration with a flow stop in the middle
      key(1'b1, LONG + 20);
      wait_hi(1);
      key(1'b0, LONG + 20);
      wait_hi(2);
      check("field_partial", partial_o, 32'h0);
      n = 1 + ($unsigned($random(seed)) % 8);
      flow(n);
      tick(20);
      flow(2);
      p_exp = 32'(n + 2) * 32'(cal_pkg::FACTORY_FACTOR);
      check("field_accum", partial_o, p_exp);
      check("field_gtotal", gtotal_o, g_exp);
      key(1'b0, DEB + 8);
      wait_hi(3);
      flow(2);
      check("frozen_partial", partial_o, p_exp);
      // close the field phase through save and restart
      exp_q.push_back('{wr: 1'b1, erase_user: 1'b1, use_user: 1'b0,
         factor: cal_pkg::FACTORY_FACTOR});
      key(1'b1, DEB + 8);
      wait_hi(0);
      check("restart_partial", partial_o, 32'h0);
      check("writes_left", 32'(exp_q.size()), 32'h0);
      finish_test;
   end
endmodule
